// *** tb/osc_counter_model.sv ***
// Ring oscillator counter model beside the debug status unit
`timescale 1ns/1ns
module osc_counter_model (
    input  wire logic             i_core_en,
    input  wire logic             i_periph_en,
    output logic      [3:0][15:0] o_count
);
    logic             ring_clk;
    logic [3:0][15:0] count_q = {16'h0fed, 16'h0abc, 16'h2468, 16'h1357};
    assign o_count = count_q;
    // ------------------------------------------------------------
    // Free-running ring, unrelated in phase to the core clock
    // ------------------------------------------------------------
    initial begin
        ring_clk = 1'b0;
        forever #7 ring_clk = ~ring_clk;
    end
    always @(posedge ring_clk) begin
        if (i_core_en) begin
            count_q[0] <= count_q[0] + 16'h0001;
            count_q[1] <= count_q[1] + 16'h0003;
        end
        if (i_periph_en) begin
            count_q[2] <= count_q[2] + 16'h0005;
            count_q[3] <= count_q[3] + 16'h0007;
        end
    end
endmodule

// *** tb/test_debug_status_breakpoint_unit.sv ***
// Self-checking bench for the debug status unit
`timescale 1ns/1ns
module test_debug_status_breakpoint_unit;
    import dbg_status_pkg::*;
    logic             i_clock, i_reset_n, hsel, hwrite, hready, hreadyout, hresp, i_pc_valid;
    logic             i_cfg_mb_we, o_core_osc_en, o_periph_osc_en, o_break_hit;
    logic [31:0]      haddr, hwdata, hrdata, i_pc, i_cfg_mb_wdata, o_cfg_mb_rdata, rd, wd, xd, tg;
    logic [1:0]       htrans, o_break_num, n;
    logic [2:0]       hsize, i_cfg_mb_idx;
    logic [7:0]       i_pc_thread, o_fetch_thread, o_stop_mask, t;
    logic [4:0]       o_fetch_reg;
    logic [3:0][15:0] osc;
    entry_req_t       i_entry;
    thread_state_t    i_entry_state, st;
    int               num_errors, samples_checked;
    assign hready = hreadyout;
    dbg_status_unit i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .i_osc_count(osc), .o_core_osc_en(o_core_osc_en), .o_periph_osc_en(o_periph_osc_en),
        .i_entry(i_entry), .i_entry_state(i_entry_state), .i_pc(i_pc),
        .i_pc_thread(i_pc_thread), .i_pc_valid(i_pc_valid), .o_break_hit(o_break_hit),
        .o_break_num(o_break_num), .o_fetch_thread(o_fetch_thread), .o_fetch_reg(o_fetch_reg),
        .o_stop_mask(o_stop_mask), .i_cfg_mb_we(i_cfg_mb_we), .i_cfg_mb_idx(i_cfg_mb_idx),
        .i_cfg_mb_wdata(i_cfg_mb_wdata), .o_cfg_mb_rdata(o_cfg_mb_rdata));
    osc_counter_model i_osc (.i_core_en(o_core_osc_en), .i_periph_en(o_periph_osc_en),
        .o_count(osc));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
        @(posedge i_clock);
        haddr <= {22'h0, ix, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge i_clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge i_clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask
    task automatic rchk(input string nm, input logic [7:0] ix, input logic [31:0] e);
        bus(1'b0, ix, 32'h0000_0000);
        check(nm, e, rd);
    endtask
    task automatic pchk(input logic [31:0] pc, input logic [7:0] th, input logic h,
                        input logic [1:0] bn);
        @(posedge i_clock);
        i_pc <= pc;
        i_pc_thread <= th;
        i_pc_valid <= 1'b1;
        @(negedge i_clock);
        check("break_hit", {31'h0, h}, {31'h0, o_break_hit});
        if (h) check("break_num", {30'h0, bn}, {30'h0, o_break_num});
        @(posedge i_clock);
        i_pc_valid <= 1'b0;
    endtask
    function automatic logic [31:0] cword(cause_t c, logic [7:0] th, logic [1:0] bn);
        return {14'h0, (c == CAUSE_HOST || c == CAUSE_CALL) ? 2'b00 : bn,
                (c == CAUSE_HOST) ? 8'h00 : th, 5'h00, c};
    endfunction
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        num_errors++;
        results();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(88));
        {hsel, hwrite, i_pc_valid, i_cfg_mb_we, i_reset_n} = 5'b10000;
        {haddr, hwdata, i_pc, i_cfg_mb_wdata, i_pc_thread, i_cfg_mb_idx, htrans} = '0;
        hsize = 3'h2;
        i_entry = '0;
        i_entry_state = '0;
        repeat (12) @(posedge i_clock);
        i_reset_n <= 1'b1;
        rchk("cause_rst", IDX_ENTRY_CAUSE, 32'h0000_0000);
        for (int b = 0; b < 4; b++) begin
            rchk("setup_rst", 8'(IDX_BREAK_SETUP + b), 0);
        end
        check("osc_en_rst", 0, {30'h0, o_core_osc_en, o_periph_osc_en});
        bus(1'b1, IDX_RAM_SIZE, $urandom);
        rchk("ram_size", IDX_RAM_SIZE, 32'h0008_0000);
        rchk("unmapped", 8'h05, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            wd = $urandom;
            t = (k == 0) ? IDX_FETCH_THREAD : (k == 1) ? IDX_FETCH_REG : IDX_STOP_MASK;
            xd = (k == 1) ? 32'h0000_001f : 32'h0000_00ff;
            bus(1'b1, t, wd);
            rchk("operand", t, wd & xd);
            rd = (k == 0) ? {24'h0, o_fetch_thread} : (k == 1) ? {27'h0, o_fetch_reg} :
                 {24'h0, o_stop_mask};
            check("operand_out", wd & xd, rd);
        end
        for (int i = 0; i < 8; i++) begin
            wd = $urandom;
            bus(1'b1, 8'(IDX_MAILBOX + i), wd);
            i_cfg_mb_idx <= 3'(i);
            @(negedge i_clock);
            check("mailbox_cfg", wd, o_cfg_mb_rdata);
            @(posedge i_clock);
            {i_cfg_mb_we, i_cfg_mb_wdata} <= {1'b1, ~wd};
            @(posedge i_clock);
            i_cfg_mb_we <= 1'b0;
            rchk("mailbox_bus", 8'(IDX_MAILBOX + i), ~wd);
        end
        xd = 32'h0000_0000;
        for (int c = 1; c < 6; c++) begin
            st = {11'($urandom) & 11'h7df, 32'($urandom), 32'($urandom)};
            {t, n, wd} = {8'($urandom), 2'($urandom), 32'($urandom)};
            @(posedge i_clock);
            i_entry <= '{1'b1, cause_t'(c), t, n, wd};
            i_entry_state <= st;
            @(posedge i_clock);
            i_entry.valid <= 1'b0;
            if (c >= 4) xd = wd;
            tg = cword(cause_t'(c), t, n);
            rchk("cause", IDX_ENTRY_CAUSE, tg);
            rchk("entry_data", IDX_ENTRY_DATA, xd);
            rchk("status", IDX_STATUS_WORD, {21'h0, st.status_word});
            rchk("pc", IDX_PROGRAM_CNT, st.program_counter);
            rchk("sp", IDX_STACK_PTR, st.stack_pointer);
        end
        bus(1'b1, IDX_STATUS_WORD, 32'hffff_ffff);
        rchk("status_wr", IDX_STATUS_WORD, {21'h0, st.status_word | STATUS_WR_MASK});
        tg = $urandom & 32'hffff_fff0;
        for (int b = 0; b < 4; b++) bus(1'b1, 8'(IDX_BREAK_TARGET + b), (b == 1) ? ~tg : tg);
        bus(1'b1, 8'(IDX_BREAK_SETUP + 3), 32'h0020_0001);
        bus(1'b1, 8'(IDX_BREAK_SETUP + 2), 32'h0020_0001);
        pchk(tg, 8'd5, 1'b1, 2'd2);
        pchk(tg, 8'd4, 1'b0, 2'd0);
        pchk(tg + 4, 8'd5, 1'b0, 2'd0);
        bus(1'b1, 8'(IDX_BREAK_SETUP + 2), 32'h0020_0000);
        pchk(tg, 8'd5, 1'b1, 2'd3);
        bus(1'b1, IDX_BREAK_SETUP, 32'h0020_0003);
        pchk(tg + 4, 8'd5, 1'b1, 2'd0);
        pchk(tg, 8'd5, 1'b1, 2'd3);
        rchk("brk_cause", IDX_ENTRY_CAUSE, 32'h0003_0503);
        bus(1'b1, 8'(IDX_BREAK_SETUP + 1), 32'hffff_ffff);
        rchk("setup_rb", 8'(IDX_BREAK_SETUP + 1), 32'h00ff_0003);
        bus(1'b1, IDX_OSC_CONTROL, 32'h0000_0003);
        @(negedge i_clock);
        check("osc_en", 3, {30'h0, o_core_osc_en, o_periph_osc_en});
        repeat (40) @(posedge i_clock);
        bus(1'b1, IDX_OSC_CONTROL, 32'h0000_0000);
        repeat (12) @(posedge i_clock);
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 4; i++) begin
                rchk("osc", 8'(IDX_TILE_CELL_OSC + i), {16'h0, osc[i]});
            end
            @(posedge i_clock);
            i_reset_n <= 1'b0;
            repeat (2) @(posedge i_clock);
            i_reset_n <= 1'b1;
        end
        results();
    end
endmodule

// *** verilog/dbg_status_pkg.sv ***
// Package: register map, field layout and carriers for the debug status unit
package dbg_status_pkg;
    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_TILE_CELL_OSC  = 8'h07;
    localparam logic [7:0] IDX_TILE_WIRE_OSC  = 8'h08;
    localparam logic [7:0] IDX_PERIPH_CELL_OSC = 8'h09;
    localparam logic [7:0] IDX_PERIPH_WIRE_OSC = 8'h0a;
    localparam logic [7:0] IDX_RAM_SIZE       = 8'h0c;
    localparam logic [7:0] IDX_OSC_CONTROL    = 8'h06;
    localparam logic [7:0] IDX_STATUS_WORD    = 8'h10;
    localparam logic [7:0] IDX_PROGRAM_CNT    = 8'h11;
    localparam logic [7:0] IDX_STACK_PTR      = 8'h12;
    localparam logic [7:0] IDX_FETCH_THREAD   = 8'h13;
    localparam logic [7:0] IDX_FETCH_REG      = 8'h14;
    localparam logic [7:0] IDX_ENTRY_CAUSE    = 8'h15;
    localparam logic [7:0] IDX_ENTRY_DATA     = 8'h16;
    localparam logic [7:0] IDX_STOP_MASK      = 8'h18;
    localparam logic [7:0] IDX_MAILBOX        = 8'h20;
    localparam logic [7:0] IDX_BREAK_TARGET   = 8'h30;
    localparam logic [7:0] IDX_BREAK_SETUP    = 8'h40;
    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int          OSC_COUNT_W      = 16;
    localparam int          STATUS_W         = 11;
    localparam logic [10:0] STATUS_WR_MASK   = 11'h6df;
    localparam int          OSC_CORE_EN_BIT  = 1;
    localparam int          OSC_PERIPH_EN_BIT = 0;
    localparam int          CAUSE_LSB        = 0;
    localparam int          THREAD_LSB       = 8;
    localparam int          BREAK_NUM_LSB    = 16;
    localparam int          SETUP_ENABLE_BIT = 0;
    localparam int          SETUP_COND_BIT   = 1;
    localparam int          SETUP_THREAD_LSB = 16;
    localparam int          NUM_THREADS      = 8;
    localparam int          NUM_BREAKS       = 4;
    localparam int          NUM_MAILBOX      = 8;
    localparam logic [2:0]  CAUSE_RESET      = 3'h0;
    localparam logic [31:0] REG_RESET        = 32'h0000_0000;

    typedef enum logic [2:0] {
        CAUSE_NONE     = 3'h0,
        CAUSE_HOST     = 3'h1,
        CAUSE_CALL     = 3'h2,
        CAUSE_IBREAK   = 3'h3,
        CAUSE_DWATCH   = 3'h4,
        CAUSE_RWATCH   = 3'h5
    } cause_t;

    // Thread state handed over by the pipeline at debug entry
    typedef struct packed {
        logic [10:0] status_word;
        logic [31:0] program_counter;
        logic [31:0] stack_pointer;
    } thread_state_t;

    // Debug entry request from the pipeline
    typedef struct packed {
        logic        valid;
        cause_t      cause;
        logic [7:0]  thread;
        logic [1:0]  watch_num;
        logic [31:0] data;
    } entry_req_t;
endpackage

// *** verilog/dbg_status_unit.sv ***
// Debug status, capture and instruction breakpoint unit on AHB-Lite
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module dbg_status_unit #(
    parameter logic [31:0] RAM_SIZE = 32'h0008_0000
) (
    input  wire logic                         i_clock,
    input  wire logic                         i_reset_n,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    input  wire logic [3:0][15:0]             i_osc_count,
    output logic                              o_core_osc_en,
    output logic                              o_periph_osc_en,
    input  wire dbg_status_pkg::entry_req_t   i_entry,
    input  wire dbg_status_pkg::thread_state_t i_entry_state,
    input  wire logic [31:0]                  i_pc,
    input  wire logic [7:0]                   i_pc_thread,
    input  wire logic                         i_pc_valid,
    output logic                              o_break_hit,
    output logic      [1:0]                   o_break_num,
    output logic      [7:0]                   o_fetch_thread,
    output logic      [4:0]                   o_fetch_reg,
    output logic      [7:0]                   o_stop_mask,
    input  wire logic                         i_cfg_mb_we,
    input  wire logic [2:0]                   i_cfg_mb_idx,
    input  wire logic [31:0]                  i_cfg_mb_wdata,
    output logic      [31:0]                  o_cfg_mb_rdata
);
    import dbg_status_pkg::*;

    // Elaboration check: the size must be a whole number of words
    if (RAM_SIZE[1:0] != 2'b00) begin : g_size_check
        $error("RAM_SIZE must be a multiple of four");
    end

    // ------------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------------
    logic        wr_pend_q;
    logic [7:0]  wr_idx_q;
    logic [7:0]  rd_idx;
    logic        rd_go;
    logic        wr_go;

    assign rd_idx    = haddr[9:2];
    assign rd_go     = hsel && hready && htrans[1] && !hwrite;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end else begin
            if (hready) begin
                wr_pend_q <= hsel && htrans[1] && hwrite;
                wr_idx_q  <= haddr[9:2];
            end
        end
    end
    assign wr_go = wr_pend_q;

    // ------------------------------------------------------------------
    // Oscillator counters: three-stage sync, no reset
    // ------------------------------------------------------------------
    logic [3:0][15:0] osc_s1_q;
    logic [3:0][15:0] osc_s2_q;
    logic [3:0][15:0] osc_s3_q;
    logic [3:0][15:0] osc_hold_q;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_osc
            always_ff @(posedge i_clock) begin
                osc_s1_q[g] <= i_osc_count[g];
                osc_s2_q[g] <= osc_s1_q[g];
                osc_s3_q[g] <= osc_s2_q[g];
                if (osc_s2_q[g] == osc_s3_q[g]) begin
                    osc_hold_q[g] <= osc_s3_q[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Oscillator control
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_core_osc_en   <= 1'b0;
            o_periph_osc_en <= 1'b0;
        end else if (wr_go && wr_idx_q == IDX_OSC_CONTROL) begin
            o_core_osc_en   <= hwdata[OSC_CORE_EN_BIT];
            o_periph_osc_en <= hwdata[OSC_PERIPH_EN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Instruction breakpoints
    // ------------------------------------------------------------------
    logic [3:0][31:0] brk_target_q;
    logic [3:0][7:0]  brk_threads_q;
    logic [3:0]       brk_cond_q;
    logic [3:0]       brk_en_q;
    logic [3:0]       brk_match;

    generate
        for (g = 0; g < 4; g++) begin : g_brk
            always_ff @(posedge i_clock) begin
                if (!i_reset_n) begin
                    brk_target_q[g]  <= REG_RESET;
                    brk_threads_q[g] <= 8'h00;
                    brk_cond_q[g]    <= 1'b0;
                    brk_en_q[g]      <= 1'b0;
                end else if (wr_go) begin
                    if (wr_idx_q == IDX_BREAK_TARGET + 8'(g)) begin
                        brk_target_q[g] <= hwdata;
                    end
                    if (wr_idx_q == IDX_BREAK_SETUP + 8'(g)) begin
                        brk_threads_q[g] <= hwdata[SETUP_THREAD_LSB +: 8];
                        brk_cond_q[g]    <= hwdata[SETUP_COND_BIT];
                        brk_en_q[g]      <= hwdata[SETUP_ENABLE_BIT];
                    end
                end
            end
            assign brk_match[g] = i_pc_valid && brk_en_q[g]
                && brk_threads_q[g][i_pc_thread[2:0]]
                && i_pc_thread[7:3] == 5'd0
                && ((i_pc == brk_target_q[g]) ^ brk_cond_q[g]);
        end
    endgenerate

    always_comb begin
        o_break_hit = |brk_match;
        o_break_num = 2'd0;
        for (int k = 3; k >= 0; k--) begin
            if (brk_match[k]) begin
                o_break_num = 2'(k);
            end
        end
    end

    // ------------------------------------------------------------------
    // Debug entry capture and software edits
    // ------------------------------------------------------------------
    logic [10:0] status_q;
    logic [31:0] pc_q;
    logic [31:0] sp_q;
    logic [2:0]  cause_q;
    logic [7:0]  thread_q;
    logic [1:0]  wnum_q;
    logic [31:0] data_q;
    logic        take_break;

    assign take_break = o_break_hit && !i_entry.valid;

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            status_q <= 11'h000;
            pc_q     <= REG_RESET;
            sp_q     <= REG_RESET;
            cause_q  <= CAUSE_RESET;
            thread_q <= 8'h00;
            wnum_q   <= 2'd0;
            data_q   <= REG_RESET;
        end else if (i_entry.valid) begin
            status_q <= i_entry_state.status_word;
            pc_q     <= i_entry_state.program_counter;
            sp_q     <= i_entry_state.stack_pointer;
            cause_q  <= i_entry.cause;
            thread_q <= (i_entry.cause == CAUSE_HOST) ? 8'h00 : i_entry.thread;
            wnum_q   <= (i_entry.cause == CAUSE_HOST || i_entry.cause == CAUSE_CALL)
                        ? 2'd0 : i_entry.watch_num;
            if (i_entry.cause == CAUSE_DWATCH || i_entry.cause == CAUSE_RWATCH) begin
                data_q <= i_entry.data;
            end
        end else if (take_break) begin
            status_q <= i_entry_state.status_word;
            pc_q     <= i_entry_state.program_counter;
            sp_q     <= i_entry_state.stack_pointer;
            cause_q  <= CAUSE_IBREAK;
            thread_q <= i_pc_thread;
            wnum_q   <= o_break_num;
        end else if (wr_go) begin
            case (wr_idx_q)
                IDX_STATUS_WORD: status_q <= (hwdata[10:0] & STATUS_WR_MASK)
                                           | (status_q & ~STATUS_WR_MASK);
                IDX_PROGRAM_CNT: pc_q <= hwdata;
                IDX_STACK_PTR:   sp_q <= hwdata;
                IDX_ENTRY_CAUSE: begin
                    cause_q  <= hwdata[CAUSE_LSB +: 3];
                    thread_q <= hwdata[THREAD_LSB +: 8];
                    wnum_q   <= hwdata[BREAK_NUM_LSB +: 2];
                end
                IDX_ENTRY_DATA:  data_q <= hwdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Fetch operands and stop mask
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_fetch_thread <= 8'h00;
            o_fetch_reg    <= 5'h00;
            o_stop_mask    <= 8'h00;
        end else if (wr_go) begin
            if (wr_idx_q == IDX_FETCH_THREAD) begin
                o_fetch_thread <= hwdata[7:0];
            end
            if (wr_idx_q == IDX_FETCH_REG) begin
                o_fetch_reg <= hwdata[4:0];
            end
            if (wr_idx_q == IDX_STOP_MASK) begin
                o_stop_mask <= hwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Mailbox shared with configuration port; bus write wins on collision
    // ------------------------------------------------------------------
    logic [31:0] mailbox_q [NUM_MAILBOX];

    generate
        for (g = 0; g < NUM_MAILBOX; g++) begin : g_mb
            always_ff @(posedge i_clock) begin
                if (!i_reset_n) begin
                    mailbox_q[g] <= REG_RESET;
                end else if (wr_go && wr_idx_q == IDX_MAILBOX + 8'(g)) begin
                    mailbox_q[g] <= hwdata;
                end else if (i_cfg_mb_we && i_cfg_mb_idx == 3'(g)) begin
                    mailbox_q[g] <= i_cfg_mb_wdata;
                end
            end
        end
    endgenerate
    assign o_cfg_mb_rdata = mailbox_q[i_cfg_mb_idx];

    // ------------------------------------------------------------------
    // Read mux, registered into the data phase
    // ------------------------------------------------------------------
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        if (rd_idx >= IDX_TILE_CELL_OSC && rd_idx <= IDX_PERIPH_WIRE_OSC) begin
            rd_d = {16'h0000, osc_hold_q[2'(rd_idx - IDX_TILE_CELL_OSC)]};
        end else if (rd_idx >= IDX_MAILBOX && rd_idx < IDX_MAILBOX + 8'd8) begin
            rd_d = mailbox_q[3'(rd_idx - IDX_MAILBOX)];
        end else if (rd_idx >= IDX_BREAK_TARGET && rd_idx < IDX_BREAK_TARGET + 8'd4) begin
            rd_d = brk_target_q[2'(rd_idx - IDX_BREAK_TARGET)];
        end else if (rd_idx >= IDX_BREAK_SETUP && rd_idx < IDX_BREAK_SETUP + 8'd4) begin
            rd_d = {8'h00, brk_threads_q[2'(rd_idx - IDX_BREAK_SETUP)], 14'h0000,
                    brk_cond_q[2'(rd_idx - IDX_BREAK_SETUP)],
                    brk_en_q[2'(rd_idx - IDX_BREAK_SETUP)]};
        end else begin
            case (rd_idx)
                IDX_OSC_CONTROL: rd_d = {30'h0, o_core_osc_en, o_periph_osc_en};
                IDX_RAM_SIZE:    rd_d = {RAM_SIZE[31:2], 2'b00};
                IDX_STATUS_WORD: rd_d = {21'h0, status_q};
                IDX_PROGRAM_CNT: rd_d = pc_q;
                IDX_STACK_PTR:   rd_d = sp_q;
                IDX_FETCH_THREAD: rd_d = {24'h0, o_fetch_thread};
                IDX_FETCH_REG:   rd_d = {27'h0, o_fetch_reg};
                IDX_ENTRY_CAUSE: rd_d = {14'h0, wnum_q, thread_q, 5'h0, cause_q};
                IDX_ENTRY_DATA:  rd_d = data_q;
                IDX_STOP_MASK:   rd_d = {24'h0, o_stop_mask};
                default:         rd_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_go) begin
            hrdata <= rd_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    cause_reset_a: assert property (@(posedge i_clock)
        !i_reset_n |=> cause_q == 3'h0) else $error("cause not cleared by reset");
    host_thread_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_entry.valid && i_entry.cause == CAUSE_HOST |=> thread_q == 8'h00 && wnum_q == 2'd0)
        else $error("host entry left thread or number nonzero");
    entry_pc_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_entry.valid |=> pc_q == $past(i_entry_state.program_counter))
        else $error("program counter not captured");
    entry_sp_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_entry.valid |=> sp_q == $past(i_entry_state.stack_pointer)
            && cause_q == $past(i_entry.cause))
        else $error("entry fields not written together");
    brk_disabled_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        brk_en_q == 4'h0 |-> !o_break_hit) else $error("disabled breakpoint fired");
    brk_lowest_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        brk_match[0] |-> o_break_num == 2'd0) else $error("lowest breakpoint not chosen");
    brk_capture_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        take_break |=> cause_q == 3'h3 && wnum_q == $past(o_break_num))
        else $error("breakpoint entry not recorded");
    ram_size_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        rd_go && rd_idx == IDX_RAM_SIZE |=> hrdata[1:0] == 2'b00 && hrdata == RAM_SIZE)
        else $error("RAM size read wrong");
    osc_upper_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        rd_go && rd_idx == IDX_TILE_WIRE_OSC |=> hrdata[31:16] == 16'h0000
            && hrdata[15:0] == $past(osc_hold_q[1]))
        else $error("oscillator readout wrong");
    osc_enable_a: assert property (@(posedge i_clock)
        !i_reset_n |=> !o_core_osc_en && !o_periph_osc_en)
        else $error("oscillator enables not cleared");
endmodule
